// file: core/sccc_top.sv
// closed-loop system clock compensation: channel error and auxiliary loop factors
// assumes reference edges and channel errors arrive asynchronously on pins
//
// What this block does
// RL1 - channel select bit D0 picks error source
// RL2 - second factor from chosen channel error
// RL3 - software never feeds factor to source
// RL4 - five-bit field picks auxiliary loop TDC
// RL5 - decode A, A complement, B, aux codes
// RL6 - auxiliary loop accepts incoming combined factor
// RL7 - third factor excludes combined factor
// RL8 - error is measured versus nominal period
// RL9 - bandwidth is 0.1 Hz times field
// RL10 - monitor reports period fault status bits
// RL11 - fixed-threshold lock detector reports lock bits
// RL12 - third factor updates each reference edge in track state
// RL13 - holdover on zero bandwidth or 1% error
// RL14 - holdover freezes NCO and third factor
// RL15 - resume updating after cause clears, locked
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "sccc_cfg.svh"
`default_nettype none
module sccc_top
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // register port
    input  wire logic [15:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    // tdc edge inputs: ref A, A complement, B, B complement, aux 0, aux 1
    input  wire logic [5:0]  TDC_EDGE,
    // channel loop frequency errors
    input  wire logic [31:0] CHAN_ERR_ZERO,
    input  wire logic [31:0] CHAN_ERR_ONE,
    // incoming combined compensation factor for the auxiliary loop
    input  wire logic [31:0] COMBINED_COMP_IN,
    // factor and status outputs
    output logic      [31:0] SECOND_FACTOR,
    output logic      [31:0] THIRD_FACTOR,
    output logic      [31:0] AUX_NCO_WORD,
    output logic             HOLDOVER,
    output logic             IRQ
);
    // ========================================
    // reset release and pin synchronisers
    logic [1:0]  rst_sync;
    logic        rst_n;
    logic [5:0]  edge_s1;
    logic [5:0]  edge_s2;
    logic [63:0] err_s1;
    logic [63:0] err_s2;
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];
    // multi-bit error words are assumed quasi-static between samples
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            edge_s1 <= 6'h00;
            edge_s2 <= 6'h00;
            err_s1  <= 64'h0;
            err_s2  <= 64'h0;
        end
        else
        begin
            edge_s1 <= TDC_EDGE;
            edge_s2 <= edge_s1;
            err_s1  <= {CHAN_ERR_ONE, CHAN_ERR_ZERO};
            err_s2  <= err_s1;
        end
    end
    // ========================================
    // state
    sccc_pkg::sccc_state_s s_reg;
    sccc_pkg::sccc_state_s s_next;
    logic        ref_level;
    logic        ref_rise;
    logic [23:0] err_abs;
    logic [23:0] limit;
    logic        cause;
    logic [31:0] resid;
    logic [3:0]  ev_set;
    always_comb
    begin
        s_next = s_reg;
        // source decode; unused codes give no edges
        ref_level = 1'b0;
        if (s_reg.aux_src == `SCCC_SRC_REF_A) // RL5
        begin
            ref_level = edge_s2[0];
        end
        else if (s_reg.aux_src == `SCCC_SRC_REF_A_COMP) // RL5
        begin
            ref_level = edge_s2[1];
        end
        else if (s_reg.aux_src == `SCCC_SRC_REF_B) // RL5
        begin
            ref_level = edge_s2[2];
        end
        else if (s_reg.aux_src == `SCCC_SRC_REF_B_COMP) // RL5
        begin
            ref_level = edge_s2[3];
        end
        else if (s_reg.aux_src == `SCCC_SRC_AUX_TDC0) // RL5
        begin
            ref_level = edge_s2[4];
        end
        else if (s_reg.aux_src == `SCCC_SRC_AUX_TDC1) // RL5
        begin
            ref_level = edge_s2[5];
        end
        s_next.edge_prev = {2'h0, ref_level};
        ref_rise = ref_level & ~s_reg.edge_prev[0]; // RL4
        // period measured in system clocks against nominal
        s_next.period_vld = 1'b0;
        if (ref_rise)
        begin
            s_next.period     = s_reg.cnt;
            s_next.period_vld = 1'b1;
            s_next.cnt        = 24'h000001;
        end
        else if (s_reg.cnt != 24'hFFFFFF)
        begin
            s_next.cnt = s_reg.cnt + 24'h000001;
        end
        err_abs = (s_reg.period >= s_reg.nom) ? s_reg.period - s_reg.nom : s_reg.nom - s_reg.period; // RL8
        limit = s_reg.nom / 24'h000064;
        if (s_reg.period_vld)
        begin
            s_next.fault = err_abs > limit; // RL10 RL13
        end
        // lock detector with fixed thresholds
        if (s_reg.period_vld)
        begin
            if (err_abs <= `SCCC_LOCK_TOL && !s_reg.fault)
            begin
                if (s_reg.lock_cnt != `SCCC_LOCK_COUNT)
                begin
                    s_next.lock_cnt = s_reg.lock_cnt + 4'h1;
                end
            end
            else
            begin
                s_next.lock_cnt = 4'h0;
            end
        end
        s_next.locked = (s_next.lock_cnt == `SCCC_LOCK_COUNT); // RL11
        // an out-of-limit period holds the loop off at once, before the fault flag catches up,
        // so it never reaches the nco or the third factor
        cause = (s_reg.bw == 16'h0000) || s_reg.fault || (s_reg.period_vld && err_abs > limit); // RL13
        // residual error only: combined factor is not part of it
        resid = {{8{1'b0}}, s_reg.period} - {{8{1'b0}}, s_reg.nom}; // RL7 RL8
        case (s_reg.state)
            sccc_pkg::ST_HOLD:
            begin
                // open loop: nco and third factor frozen
                if (!cause)
                begin
                    s_next.state = sccc_pkg::ST_ACQUIRE; // RL15
                end
            end
            sccc_pkg::ST_ACQUIRE:
            begin
                if (cause)
                begin
                    s_next.state = sccc_pkg::ST_HOLD;
                end
                else
                begin
                    if (s_reg.period_vld)
                    begin
                        s_next.nco_acc = s_reg.nco_acc + resid * {16'h0000, s_reg.bw}; // RL9
                    end
                    if (s_reg.locked)
                    begin
                        s_next.state = sccc_pkg::ST_TRACK; // RL15
                    end
                end
            end
            default:
            begin
                if (cause)
                begin
                    s_next.state = sccc_pkg::ST_HOLD; // RL14
                end
                else if (s_reg.period_vld)
                begin
                    // loop gain scales with bandwidth field in 0.1 Hz steps
                    s_next.nco_acc = s_reg.nco_acc + resid * {16'h0000, s_reg.bw}; // RL9
                    s_next.cf3 = resid; // RL12
                end
                if (!s_reg.locked && !cause)
                begin
                    s_next.state = sccc_pkg::ST_ACQUIRE;
                end
            end
        endcase
        s_next.cf2 = s_reg.chan_sel ? err_s2[63:32] : err_s2[31:0]; // RL1 RL2
        // events, set wins over write-one clear
        ev_set = {s_next.fault & ~s_reg.fault, ~s_next.fault & s_reg.fault,
                  s_next.locked & ~s_reg.locked, ~s_next.locked & s_reg.locked};
        if (WR && ADDR == `SCCC_OFF_EVENT_STAT)
        begin
            s_next.ev = s_reg.ev & ~WDATA[3:0];
        end
        s_next.ev = s_next.ev | {ev_set[3], ev_set[2], ev_set[1], ev_set[0]}; // RL10 RL11
        // register writes
        if (WR)
        begin
            if (ADDR == `SCCC_OFF_AUX_SRC)
            begin
                s_next.aux_src = WDATA[4:0]; // RL4
            end
            else if (ADDR == `SCCC_OFF_AUX_BW_LO)
            begin
                s_next.bw[7:0] = WDATA; // RL9
            end
            else if (ADDR == `SCCC_OFF_AUX_BW_HI)
            begin
                s_next.bw[15:8] = WDATA; // RL9
            end
            else if (ADDR == `SCCC_OFF_CHAN_SRC)
            begin
                s_next.chan_sel = WDATA[`SCCC_CHAN_SEL_BIT]; // RL1
            end
            else if (ADDR == `SCCC_OFF_IRQ_MASK)
            begin
                s_next.mask = WDATA[3:0];
            end
            else if (ADDR == `SCCC_OFF_NOM_PERIOD0)
            begin
                s_next.nom[7:0] = WDATA;
            end
            else if (ADDR == `SCCC_OFF_NOM_PERIOD1)
            begin
                s_next.nom[15:8] = WDATA;
            end
            else if (ADDR == `SCCC_OFF_NOM_PERIOD2)
            begin
                s_next.nom[23:16] = WDATA;
            end
        end
        // register reads, unmapped reads return zero
        s_next.rdata = 8'h00;
        if (RD)
        begin
            if (ADDR == `SCCC_OFF_AUX_SRC)
            begin
                s_next.rdata = {3'h0, s_reg.aux_src};
            end
            else if (ADDR == `SCCC_OFF_AUX_BW_LO)
            begin
                s_next.rdata = s_reg.bw[7:0];
            end
            else if (ADDR == `SCCC_OFF_AUX_BW_HI)
            begin
                s_next.rdata = s_reg.bw[15:8];
            end
            else if (ADDR == `SCCC_OFF_CHAN_SRC)
            begin
                s_next.rdata = {7'h00, s_reg.chan_sel};
            end
            else if (ADDR == `SCCC_OFF_LIVE_STAT)
            begin
                s_next.rdata = {5'h00, s_reg.fault, s_reg.locked, 1'b0}; // RL10 RL11
            end
            else if (ADDR == `SCCC_OFF_EVENT_STAT)
            begin
                s_next.rdata = {4'h0, s_reg.ev};
            end
            else if (ADDR == `SCCC_OFF_IRQ_MASK)
            begin
                s_next.rdata = {4'h0, s_reg.mask};
            end
            else if (ADDR == `SCCC_OFF_NOM_PERIOD0)
            begin
                s_next.rdata = s_reg.nom[7:0];
            end
            else if (ADDR == `SCCC_OFF_NOM_PERIOD1)
            begin
                s_next.rdata = s_reg.nom[15:8];
            end
            else if (ADDR == `SCCC_OFF_NOM_PERIOD2)
            begin
                s_next.rdata = s_reg.nom[23:16];
            end
            else if (ADDR == `SCCC_OFF_CF3_0)
            begin
                s_next.rdata = s_reg.cf3[7:0];
            end
            else if (ADDR == `SCCC_OFF_CF3_1)
            begin
                s_next.rdata = s_reg.cf3[15:8];
            end
            else if (ADDR == `SCCC_OFF_CF3_2)
            begin
                s_next.rdata = s_reg.cf3[23:16];
            end
            else if (ADDR == `SCCC_OFF_CF3_3)
            begin
                s_next.rdata = s_reg.cf3[31:24];
            end
        end
    end
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg          <= '0;
            s_reg.aux_src  <= `SCCC_RST_AUX_SRC;
            s_reg.bw       <= `SCCC_RST_BW;
            s_reg.nom      <= `SCCC_RST_NOM_PERIOD;
            s_reg.state    <= sccc_pkg::ST_HOLD;
        end
        else
        begin
            s_reg <= s_next;
        end
    end
    // ========================================
    // outputs
    assign RDATA         = s_reg.rdata;
    assign SECOND_FACTOR = s_reg.cf2;
    assign THIRD_FACTOR  = s_reg.cf3; // RL7
    // combined factor steers the nco only, never the third factor
    assign AUX_NCO_WORD  = s_reg.nco_acc + COMBINED_COMP_IN; // RL6
    assign HOLDOVER      = (s_reg.state == sccc_pkg::ST_HOLD);
    assign IRQ           = |(s_reg.ev & s_reg.mask);
endmodule
`default_nettype wire

// file: core/sccc_cfg.svh
// constants for the closed-loop system clock compensation block
// assumes byte-wide register port with 16-bit addresses
`ifndef SCCC_CFG_SVH
`define SCCC_CFG_SVH
// ========================================
// register offsets
`define SCCC_OFF_AUX_SRC      16'h0284
`define SCCC_OFF_AUX_BW_LO    16'h0285
`define SCCC_OFF_AUX_BW_HI    16'h0286
`define SCCC_OFF_CHAN_SRC     16'h0287
`define SCCC_OFF_LIVE_STAT    16'h3002
`define SCCC_OFF_EVENT_STAT   16'h300C
`define SCCC_OFF_IRQ_MASK     16'h300D
`define SCCC_OFF_NOM_PERIOD0  16'h3010
`define SCCC_OFF_NOM_PERIOD1  16'h3011
`define SCCC_OFF_NOM_PERIOD2  16'h3012
`define SCCC_OFF_CF3_0        16'h3020
`define SCCC_OFF_CF3_1        16'h3021
`define SCCC_OFF_CF3_2        16'h3022
`define SCCC_OFF_CF3_3        16'h3023
// ========================================
// field positions and reset values
`define SCCC_CHAN_SEL_BIT     0
`define SCCC_LIVE_FAULT_BIT   2
`define SCCC_LIVE_LOCK_BIT    1
`define SCCC_EV_UNLOCKED_BIT  0
`define SCCC_EV_LOCKED_BIT    1
`define SCCC_EV_UNFAULT_BIT   2
`define SCCC_EV_FAULT_BIT     3
`define SCCC_RST_AUX_SRC      5'h00
`define SCCC_RST_BW           16'h0000
`define SCCC_RST_NOM_PERIOD   24'h0003E8
// ========================================
// source codes
`define SCCC_SRC_REF_A        5'h00
`define SCCC_SRC_REF_A_COMP   5'h01
`define SCCC_SRC_REF_B        5'h02
`define SCCC_SRC_REF_B_COMP   5'h03
`define SCCC_SRC_AUX_TDC0     5'h06
`define SCCC_SRC_AUX_TDC1     5'h07
// ========================================
// timing and thresholds
`define SCCC_LOCK_TOL         24'h000002
`define SCCC_LOCK_COUNT       4'h8
`endif

// file: core/sccc_pkg.sv
// types for the closed-loop system clock compensation block
// assumes sccc_cfg.svh is on the include path
package sccc_pkg;
    typedef enum logic [1:0] {ST_HOLD, ST_ACQUIRE, ST_TRACK} sccc_state_e;
    typedef struct packed {
        logic [4:0]  aux_src;
        logic [15:0] bw;
        logic        chan_sel;
        logic [23:0] nom;
        logic [3:0]  ev;
        logic [3:0]  mask;
        logic [23:0] cnt;
        logic [23:0] period;
        logic        period_vld;
        logic        fault;
        logic        locked;
        logic [3:0]  lock_cnt;
        logic [31:0] nco_acc;
        logic [31:0] cf3;
        logic [31:0] cf2;
        logic [7:0]  rdata;
        logic [2:0]  edge_prev;
        sccc_state_e state;
    } sccc_state_s;
endpackage

// file: tb/sccc_assertions.sv
// concurrent checks on the compensation block top ports
// assumes a bind to sccc_top and one clock domain
`timescale 1ns/1ps
`default_nettype none
module sccc_chk
(
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST_N,
    // register port
    input wire logic [15:0] ADDR,
    input wire logic [7:0]  WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    // factors and status
    input wire logic [31:0] CHAN_ERR_ONE,
    input wire logic [31:0] COMBINED_COMP_IN,
    input wire logic [31:0] SECOND_FACTOR,
    input wire logic [31:0] THIRD_FACTOR,
    input wire logic [31:0] AUX_NCO_WORD,
    input wire logic        HOLDOVER,
    input wire logic        IRQ
);
    // ==========
    // bandwidth shadow rebuilt from writes, zero-age counter
    logic [15:0] bw_reg;
    logic [15:0] bw_next;
    logic [1:0]  zcnt_reg;
    logic [1:0]  zcnt_next;
    logic [31:0] acc;
    assign acc = AUX_NCO_WORD - COMBINED_COMP_IN;
    always_comb
    begin
        bw_next = bw_reg;
        if (WR && ADDR == 16'h0285)
            bw_next[7:0] = WDATA;
        if (WR && ADDR == 16'h0286)
            bw_next[15:8] = WDATA;
        zcnt_next = (bw_reg != 16'h0000) ? 2'h0 : ((zcnt_reg == 2'h3) ? 2'h3 : zcnt_reg + 2'h1);
    end
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            bw_reg <= 16'h0000;
            zcnt_reg <= 2'h0;
        end
        else
        begin
            bw_reg <= bw_next;
            zcnt_reg <= zcnt_next;
        end
    end
    // ==========
    // properties
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    AST_CHAN_SEL:
        assert property (WR && ADDR == 16'h0287 && WDATA[0] && $stable(CHAN_ERR_ONE)
            |-> ##[1:4] SECOND_FACTOR == CHAN_ERR_ONE) else $error("second factor not channel one");
    AST_NCO_STATIC:
        assert property (HOLDOVER && $past(HOLDOVER) |-> $stable(acc)) else $error("nco moved in holdover");
    AST_CF3_FROZEN:
        assert property (HOLDOVER && $past(HOLDOVER) |-> $stable(THIRD_FACTOR)) else $error("cf3 moved in holdover");
    AST_CF3_UPDATE:
        assert property (!$stable(THIRD_FACTOR) |-> !$past(HOLDOVER)) else $error("cf3 updated out of track");
    AST_BW_ZERO:
        assert property (zcnt_reg == 2'h3 && bw_reg == 16'h0000 |-> HOLDOVER) else $error("zero bandwidth not held");
    AST_FAULT_HOLD:
        assert property ((RD && ADDR == 16'h3002) ##1 RDATA[2] |-> ##[0:2] HOLDOVER) else $error("fault without holdover");
    AST_LIVE_RSVD:
        assert property (RD && ADDR == 16'h3002 |=> RDATA[7:3] == 5'h00 && !RDATA[0]) else $error("live status spare bits");
    AST_IRQ_MASKED:
        assert property (WR && ADDR == 16'h300D && WDATA[3:0] == 4'h0 |=> !IRQ) else $error("irq while all masked");
    cover property (HOLDOVER ##1 !HOLDOVER);
    cover property (!$stable(THIRD_FACTOR));
    cover property (IRQ);
endmodule
bind sccc_top sccc_chk u_chk
(
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .CHAN_ERR_ONE(CHAN_ERR_ONE), .COMBINED_COMP_IN(COMBINED_COMP_IN), .SECOND_FACTOR(SECOND_FACTOR),
    .THIRD_FACTOR(THIRD_FACTOR), .AUX_NCO_WORD(AUX_NCO_WORD), .HOLDOVER(HOLDOVER), .IRQ(IRQ)
);
`default_nettype wire

// file: tb/sccc_ref_model.sv
// stable external reference driving one tdc line
// assumes period in clock cycles, at least 2
`timescale 1ns/1ps
`default_nettype none
module sccc_ref_src
(
    // clock
    input  wire logic        clk,
    // control
    input  wire logic        en,
    input  wire logic [15:0] period,
    input  wire logic [2:0]  idx,
    // tdc lines
    output logic      [5:0]  tdc_o
);
    int cnt = 0;
    // ==========
    // square wave on the chosen line; others idle low, as unconnected inputs would
    always @(posedge clk)
    begin
        cnt = (cnt + 1 >= int'(period)) ? 0 : cnt + 1;
        tdc_o <= en ? (6'(cnt < int'(period) / 2) << idx) : 6'h00;
    end
endmodule
`default_nettype wire

// file: tb/sysclk_closed_loop_comp_tb.sv
// self-checking bench for the compensation block
// assumes sccc_ref_src as the stable reference
`timescale 1ns/1ps
`default_nettype none
module sysclk_closed_loop_comp_tb;
    // ==========
    // signals and model state
    logic        CLK;
    logic        RST_N;
    logic [15:0] ADDR;
    logic [7:0]  WDATA;
    logic        WR;
    logic        RD;
    logic [7:0]  RDATA;
    logic [5:0]  TDC_EDGE;
    logic [31:0] CHAN_ERR_ZERO;
    logic [31:0] CHAN_ERR_ONE;
    logic [31:0] COMBINED_COMP_IN;
    logic [31:0] SECOND_FACTOR;
    logic [31:0] THIRD_FACTOR;
    logic [31:0] AUX_NCO_WORD;
    logic        HOLDOVER;
    logic        IRQ;
    logic        ref_en;
    logic [15:0] ref_per;
    logic [2:0]  ref_idx;
    logic [31:0] a;
    int          fail_count = 0;
    int          n_tests = 0;
    int          seed = 32'h28c2;
    int          exp_cf3 = 0;
    int          codes[$] = '{0, 1, 2, 3, 6, 7};
    sccc_top dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .TDC_EDGE(TDC_EDGE), .CHAN_ERR_ZERO(CHAN_ERR_ZERO), .CHAN_ERR_ONE(CHAN_ERR_ONE),
        .COMBINED_COMP_IN(COMBINED_COMP_IN), .SECOND_FACTOR(SECOND_FACTOR), .THIRD_FACTOR(THIRD_FACTOR),
        .AUX_NCO_WORD(AUX_NCO_WORD), .HOLDOVER(HOLDOVER), .IRQ(IRQ));
    sccc_ref_src u_ref (.clk(CLK), .en(ref_en), .period(ref_per), .idx(ref_idx), .tdc_o(TDC_EDGE));
    // ==========
    // tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= ad;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rd(input logic [15:0] ad, input logic [7:0] m, input logic [7:0] exp);
        @(posedge CLK);
        ADDR <= ad;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk("rdata", {24'h0, exp}, {24'h0, RDATA & m});
        @(posedge CLK);
    endtask
    // bounded wait; the design paces holdover by reference periods
    task automatic wait_hold(input logic v);
        int n = 0;
        #1;
        while (HOLDOVER !== v && n < 5000)
        begin
            @(posedge CLK);
            #1;
            n++;
        end
        chk("holdover", {31'h0, v}, {31'h0, HOLDOVER});
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========
    // clock, watchdog, sequence
    initial
    begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    initial
    begin
        repeat (40000) @(posedge CLK);
        fail_count++;
        end_sim();
    end
    initial
    begin
        RST_N = 1'b0;
        {ADDR, WDATA, WR, RD, CHAN_ERR_ZERO, CHAN_ERR_ONE, COMBINED_COMP_IN} = '0;
        {ref_en, ref_idx} = '0;
        ref_per = 16'h0082;
        repeat (8) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge CLK);
        for (int i = 0; i < 4; i++)
            rd(16'h0284 + 16'(i), 8'hFF, 8'h00);
        rd(16'h0100, 8'hFF, 8'h00);
        chk("hold rst", 32'h1, {31'h0, HOLDOVER});
        CHAN_ERR_ZERO <= $random(seed);
        CHAN_ERR_ONE <= $random(seed);
        // no combined factor is routed back to the chosen channel here
        for (int s = 0; s < 2; s++)
        begin
            wr(16'h0287, 8'(s));
            repeat (4) @(posedge CLK);
            #1 chk("second", s ? CHAN_ERR_ONE : CHAN_ERR_ZERO, SECOND_FACTOR);
        end
        wr(16'h3010, 8'h64);
        wr(16'h3011, 8'h00);
        wr(16'h3012, 8'h00);
        wr(16'h0285, 8'hAC);
        wr(16'h0286, 8'h09);
        wr(16'h300D, 8'h08);
        ref_en <= 1'b1;
        foreach (codes[i])
        begin
            wr(16'h0284, 8'(codes[i]));
            ref_idx <= 3'(i);
            ref_per <= 16'h0082;
            wait_hold(1'b1);
            repeat (4 * 130) @(posedge CLK);
            #1 chk("cf3 hold", exp_cf3, THIRD_FACTOR);
            chk("irq", 32'h1, {31'h0, IRQ});
            rd(16'h3002, 8'h04, 8'h04);
            ref_per <= 16'(99 + i % 3);
            exp_cf3 = i % 3 - 1;
            wait_hold(1'b0);
            repeat (12 * 101) @(posedge CLK);
            #1 chk("cf3", exp_cf3, THIRD_FACTOR);
            rd(16'h3002, 8'hFF, 8'h02);
            rd(16'h300C, 8'h0E, 8'h0E);
            wr(16'h300C, 8'h0F);
            #1 chk("irq clr", 32'h0, {31'h0, IRQ});
        end
        wr(16'h0284, 8'h04);
        ref_per <= 16'h0082;
        repeat (6 * 130) @(posedge CLK);
        #1 chk("unused src", 32'h0, {31'h0, HOLDOVER});
        wr(16'h0285, 8'h00);
        wr(16'h0286, 8'h00);
        wait_hold(1'b1);
        a = AUX_NCO_WORD;
        repeat (4 * 130) @(posedge CLK);
        #1 chk("nco hold", a, AUX_NCO_WORD);
        @(posedge CLK);
        COMBINED_COMP_IN <= $random(seed);
        #1 chk("nco comb", a + COMBINED_COMP_IN, AUX_NCO_WORD);
        wr(16'h0284, 8'h07);
        ref_per <= 16'h0063;
        wr(16'h0285, 8'hAC);
        wait_hold(1'b0);
        repeat (12 * 101) @(posedge CLK);
        #1 chk("cf3 comb", 32'hFFFFFFFF, THIRD_FACTOR);
        wr(16'h300D, 8'h00);
        ref_per <= 16'h0082;
        wait_hold(1'b1);
        repeat (4 * 130) @(posedge CLK);
        #1 chk("irq masked", 32'h0, {31'h0, IRQ});
        end_sim();
    end
endmodule
`default_nettype wire
